// *** dv/vrc_reference_control_test.sv ***
`timescale 1ns/100ps
module vrc_reference_control_test
    import vrc_pkg::*;
;
    localparam logic [11:0] CTRL = {VRC_CTRL_INDEX, 2'h0};
    localparam logic [11:0] STAT = {VRC_STAT_INDEX, 2'h0};
    logic aclk = 1'h0, aresetn = 1'h0, dir = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, pwr, pin, low;
    logic [1:0] bresp, rresp;
    logic [4:0] tap;
    int mismatches = 0, n_checks = 0;

    always #20 aclk = ~aclk;

    vrc_reference_control i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_a_direction_bit2(dir), .ref_power_on(pwr),
        .analog_out_pin_drive(pin), .ref_tap_scale_low(low), .ref_tap_index(tap));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("mismatches %0d checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // the leading edge keeps a new request apart from the previous release
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd

    // expected {power, pin drive, low range, tap} from control byte and pin direction
    function automatic logic [7:0] ex(input logic [7:0] c, input logic d);
        return {c[7], c[6] & d, c[5], c[5] ? {1'h0, c[3:0]} : 5'h08 + {1'h0, c[3:0]}};
    endfunction : ex

    initial begin : main
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] e;
        logic [7:0] v [6];
        v = '{8'hff, 8'h4a, 8'h5f, 8'ha6, 8'h30, 8'hc0};
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(CTRL, d, r);
        chk(d, 32'h0);
        chk({pwr, pin, low, tap}, 32'h08);
        foreach (v[i]) begin
            dir <= i[0];
            e = ex(v[i], i[0]);
            wr(CTRL, v[i], 4'h1, r);
            chk(r, VRC_RESP_OKAY);
            rd(CTRL, d, r);
            chk(d, v[i] & 8'hef);
            chk({pwr, pin, low, tap}, e);
            rd(STAT, d, r);
            chk(d, {e[4:0], 1'h0, e[5], e[6], e[7]});
        end
        wr(CTRL, 8'h00, 4'h0, r);
        chk(r, VRC_RESP_OKAY);
        wr(STAT, 8'hff, 4'h1, r);
        chk(r, VRC_RESP_SLVERR);
        rd(CTRL, d, r);
        chk(d, 32'hc0);
        // software drops the enable ahead of sleep, pin drive stays
        wr(CTRL, 8'h40, 4'h1, r);
        rd(CTRL, d, r);
        chk(d, 32'h40);
        chk({pwr, pin}, 32'h1);
        rd(12'h004, d, r);
        chk(d, 32'h0);
        chk(r, VRC_RESP_SLVERR);
        // a second reset mid-run must clear a non-zero control byte
        aresetn <= 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(CTRL, d, r);
        chk(d, 32'h0);
        chk({pwr, pin, low, tap}, 32'h08);
        end_of_test();
    end

    // the sequence needs about a hundred cycles; far more means a stuck handshake
    initial begin : watchdog
        repeat (4000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
endmodule : vrc_reference_control_test

// *** src/vrc_pkg.sv ***
package vrc_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [9:0] VRC_CTRL_INDEX = 10'h09f;
    localparam logic [9:0] VRC_STAT_INDEX = 10'h0a0;
    localparam int VRC_ADDR_W = 12;
    localparam logic [7:0] VRC_CTRL_RESET = 8'h00;
    // bit 4 of the control byte is unimplemented
    localparam logic [7:0] VRC_CTRL_WMASK = 8'hef;
    localparam int VRC_EN_POS = 7;
    localparam int VRC_PIN_POS = 6;
    localparam int VRC_RANGE_POS = 5;
    localparam int VRC_LEVEL_LSB = 0;
    // status word field positions
    localparam int VRC_ST_POWER_POS = 0;
    localparam int VRC_ST_PIN_POS = 1;
    localparam int VRC_ST_LOW_POS = 2;
    localparam int VRC_ST_TAP_LSB = 4;
    // high range starts one quarter up the 32-step ladder
    localparam logic [4:0] VRC_HIGH_TAP_BASE = 5'h08;
    localparam logic [1:0] VRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] VRC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ref_enable;
        logic ref_pin_drive_enable;
        logic ref_range_select;
        logic unused;
        logic [3:0] ref_level_code;
    } vrc_ctrl_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [VRC_ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        vrc_ctrl_t ctrl;
        logic power_on;
        logic pin_drive;
        logic scale_low;
        logic [4:0] tap;
    } vrc_state_t;
endpackage : vrc_pkg

// *** src/vrc_reference_control.sv ***
`timescale 1ns/100ps
// Operation
// - reset clears the reference enable bit
// - reset clears the pin drive enable
// - reset clears range select, high range
// - reset clears the four-bit level code
// - sleep wake-up leaves control register unchanged
// - pin driven only when direction and enable set
// - reference independent of comparator configuration
// - enable bit powers the reference circuit
// - low range tap is level over 24
// - high range tap is quarter plus level/32
module vrc_reference_control
    import vrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [VRC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [VRC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_a_direction_bit2,
    output logic ref_power_on,
    output logic analog_out_pin_drive,
    output logic ref_tap_scale_low,
    output logic [4:0] ref_tap_index
);

    vrc_state_t st;
    vrc_state_t next_st;
    logic wr_fire;
    logic wr_hit;

    assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
    assign wr_hit = (st.awaddr[VRC_ADDR_W-1:2] == VRC_CTRL_INDEX);

    always_comb begin
        next_st = st;
        // write address and data are taken independently, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'h1;
            next_st.awready = 1'h0;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'h1;
            next_st.wready = 1'h0;
            next_st.wdata = s_axi_wdata[7:0];
            next_st.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            next_st.bvalid = 1'h1;
            // status register is read-only; writes to it or elsewhere are refused
            next_st.bresp = wr_hit ? VRC_RESP_OKAY : VRC_RESP_SLVERR;
            // only a completed bus write changes the control byte; sleep has no path here
            if (wr_hit && st.wstrb0) begin
                next_st.ctrl = vrc_ctrl_t'(st.wdata & VRC_CTRL_WMASK);
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'h0;
            next_st.aw_got = 1'h0;
            next_st.w_got = 1'h0;
            next_st.awready = 1'h1;
            next_st.wready = 1'h1;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'h0;
            next_st.rvalid = 1'h1;
            next_st.rresp = VRC_RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            if (s_axi_araddr[VRC_ADDR_W-1:2] == VRC_CTRL_INDEX) begin
                next_st.rdata[7:0] = st.ctrl & VRC_CTRL_WMASK;
            end else if (s_axi_araddr[VRC_ADDR_W-1:2] == VRC_STAT_INDEX) begin
                next_st.rdata[VRC_ST_POWER_POS] = st.power_on;
                next_st.rdata[VRC_ST_PIN_POS] = st.pin_drive;
                next_st.rdata[VRC_ST_LOW_POS] = st.scale_low;
                next_st.rdata[VRC_ST_TAP_LSB +: 5] = st.tap;
            end else begin
                next_st.rresp = VRC_RESP_SLVERR;
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'h0;
            next_st.arready = 1'h1;
        end
        // analog controls follow the control byte one cycle later;
        // nothing from the comparator reaches these terms
        next_st.power_on = st.ctrl.ref_enable;
        next_st.pin_drive = port_a_direction_bit2 && st.ctrl.ref_pin_drive_enable;
        next_st.scale_low = st.ctrl.ref_range_select;
        if (st.ctrl.ref_range_select) begin
            next_st.tap = {1'h0, st.ctrl.ref_level_code};
        end else begin
            next_st.tap = VRC_HIGH_TAP_BASE + {1'h0, st.ctrl.ref_level_code};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.awready <= 1'h1;
            st.wready <= 1'h1;
            st.arready <= 1'h1;
            st.ctrl <= vrc_ctrl_t'(VRC_CTRL_RESET);
            st.tap <= VRC_HIGH_TAP_BASE;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign ref_power_on = st.power_on;
    assign analog_out_pin_drive = st.pin_drive;
    assign ref_tap_scale_low = st.scale_low;
    assign ref_tap_index = st.tap;

    property p_rst_enable;
        @(posedge aclk) !aresetn |=> !st.ctrl.ref_enable ##1 !ref_power_on;
    endproperty
    a_rst_enable: assert property (p_rst_enable) else $error("reset left enable set");

    property p_rst_pin;
        @(posedge aclk) !aresetn |=> !st.ctrl.ref_pin_drive_enable && !analog_out_pin_drive;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset left pin drive set");

    property p_rst_range;
        @(posedge aclk) !aresetn |=> !st.ctrl.ref_range_select && !ref_tap_scale_low;
    endproperty
    a_rst_range: assert property (p_rst_range) else $error("reset left low range");

    property p_rst_level;
        @(posedge aclk) !aresetn |=> st.ctrl.ref_level_code == 4'h0
            && ref_tap_index == VRC_HIGH_TAP_BASE;
    endproperty
    a_rst_level: assert property (p_rst_level) else $error("reset left level code");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
            !wr_fire |=> $stable(st.ctrl);
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");

    property p_pin;
        @(posedge aclk) disable iff (!aresetn)
            ##1 (analog_out_pin_drive == $past(port_a_direction_bit2
            && st.ctrl.ref_pin_drive_enable));
    endproperty
    a_pin: assert property (p_pin) else $error("pin drive gating wrong");

    property p_pin_off;
        @(posedge aclk) disable iff (!aresetn)
            !port_a_direction_bit2 |=> !analog_out_pin_drive;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven with direction clear");

    property p_power;
        @(posedge aclk) disable iff (!aresetn)
            wr_fire && wr_hit && st.wstrb0 |=> ##1 ref_power_on == $past(st.wdata[7], 2);
    endproperty
    a_power: assert property (p_power) else $error("power does not follow enable");

    property p_power_off;
        @(posedge aclk) disable iff (!aresetn)
            !st.ctrl.ref_enable |=> !ref_power_on;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power on with enable clear");

    property p_low;
        @(posedge aclk) disable iff (!aresetn)
            st.ctrl.ref_range_select |=> ref_tap_scale_low
            && ref_tap_index == {1'h0, $past(st.ctrl.ref_level_code)};
    endproperty
    a_low: assert property (p_low) else $error("low range tap wrong");

    // the 24-step ladder only has taps 0 to 15 in reach
    property p_low_span;
        @(posedge aclk) disable iff (!aresetn)
            ref_tap_scale_low |-> !ref_tap_index[4];
    endproperty
    a_low_span: assert property (p_low_span) else $error("low range tap out of span");

    property p_high;
        @(posedge aclk) disable iff (!aresetn)
            !st.ctrl.ref_range_select |=> !ref_tap_scale_low
            && ref_tap_index == VRC_HIGH_TAP_BASE + {1'h0, $past(st.ctrl.ref_level_code)};
    endproperty
    a_high: assert property (p_high) else $error("high range tap wrong");

    property p_write;
        @(posedge aclk) disable iff (!aresetn)
            wr_fire && wr_hit && st.wstrb0 |=> st.ctrl == ($past(st.wdata) & VRC_CTRL_WMASK);
    endproperty
    a_write: assert property (p_write) else $error("write not taken in one clock");

    // status reads carry tap bit 0 in bit 4, so only control reads are held to zero
    property p_bit4;
        @(posedge aclk) disable iff (!aresetn)
            s_axi_arvalid && s_axi_arready
            && s_axi_araddr[VRC_ADDR_W-1:2] == VRC_CTRL_INDEX
            |=> !s_axi_rdata[4] && !st.ctrl.unused;
    endproperty
    a_bit4: assert property (p_bit4) else $error("bit 4 not zero");

endmodule : vrc_reference_control
